// ==== hdl/its_pkg.sv ====
// Constants and operation codes for the instruction tail execution unit.
`default_nettype none
package its_pkg;
    localparam int DATA_WIDTH = 8;
    localparam int PROG_WIDTH = 16;
    localparam int PAGE_WIDTH = 8;
    localparam int BIT_SEL_WIDTH = 3;
    localparam int NIBBLE_WIDTH = 4;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [7:0] TABLE_HIGH_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FINAL_PAGE = 8'hFF;
    localparam logic ZERO_FLAG_RESET = 1'b0;

    typedef enum logic [3:0] {
        ITS_OP_NONE,
        ITS_OP_NIBBLE_EXCHANGE,
        ITS_OP_NIBBLE_EXCHANGE_TO_WORKING,
        ITS_OP_SKIP_IF_ZERO,
        ITS_OP_COPY_THEN_SKIP_ON_ZERO,
        ITS_OP_SKIP_IF_BIT_ZERO,
        ITS_OP_READ_TABLE_GIVEN_PAGE,
        ITS_OP_READ_TABLE_CURRENT_PAGE,
        ITS_OP_READ_TABLE_FINAL_PAGE,
        ITS_OP_EXCLUSIVE_OR_TO_WORKING,
        ITS_OP_EXCLUSIVE_OR_INTO_MEMORY,
        ITS_OP_EXCLUSIVE_OR_IMMEDIATE
    } its_op_type;

    typedef enum {
        ITS_ST_IDLE,
        ITS_ST_TABLE_FETCH,
        ITS_ST_SKIP_SLOT
    } its_state_type;
endpackage : its_pkg
`default_nettype wire

// ==== hdl/its_exec.sv ====
// Execution unit for nibble exchange, zero-test skips, table reads and exclusive-OR.
`default_nettype none
module its_exec
    import its_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    input  wire logic                        issue_valid,
    input  wire its_pkg::its_op_type         issue_op,
    input  wire logic [its_pkg::BIT_SEL_WIDTH-1:0] bit_select,
    input  wire logic [its_pkg::DATA_WIDTH-1:0]    literal,
    input  wire logic [its_pkg::DATA_WIDTH-1:0]    mem_read_data,
    input  wire logic [its_pkg::PAGE_WIDTH-1:0]    table_pointer_low,
    input  wire logic [its_pkg::PAGE_WIDTH-1:0]    table_pointer_high,
    input  wire logic [its_pkg::PAGE_WIDTH-1:0]    current_page,
    input  wire logic [its_pkg::PROG_WIDTH-1:0]    prog_read_data,
    output logic                             issue_ready,
    output logic                             mem_write_en,
    output logic [its_pkg::DATA_WIDTH-1:0]   mem_write_data,
    output logic [its_pkg::PROG_WIDTH-1:0]   prog_addr,
    output logic                             prog_read_en,
    output logic [its_pkg::DATA_WIDTH-1:0]   working_register,
    output logic [its_pkg::DATA_WIDTH-1:0]   table_high_latch,
    output logic                             zero_flag,
    output logic                             skip_slot
);
    import its_pkg::*;

    // ==================================================================
    // Operand decode
    // ==================================================================
    its_state_type state;
    its_state_type next_state;
    wire                   accept      = issue_valid && issue_ready;
    wire [DATA_WIDTH-1:0]  swapped     = {mem_read_data[NIBBLE_WIDTH-1:0],
                                          mem_read_data[DATA_WIDTH-1:NIBBLE_WIDTH]};
    wire [DATA_WIDTH-1:0]  xor_mem     = working_register ^ mem_read_data;
    wire [DATA_WIDTH-1:0]  xor_imm     = working_register ^ literal;
    wire                   byte_zero   = (mem_read_data == ZERO_BYTE);
    wire                   bit_zero    = ~mem_read_data[bit_select];
    wire                   op_table    = (issue_op == ITS_OP_READ_TABLE_GIVEN_PAGE)
                                      || (issue_op == ITS_OP_READ_TABLE_CURRENT_PAGE)
                                      || (issue_op == ITS_OP_READ_TABLE_FINAL_PAGE);
    // A skip is taken only when the tested value is zero.
    wire                   skip_taken  = accept && (
                               ((issue_op == ITS_OP_SKIP_IF_ZERO) && byte_zero)
                            || ((issue_op == ITS_OP_COPY_THEN_SKIP_ON_ZERO) && byte_zero)
                            || ((issue_op == ITS_OP_SKIP_IF_BIT_ZERO) && bit_zero));
    wire [PAGE_WIDTH-1:0]  table_page  =
        (issue_op == ITS_OP_READ_TABLE_GIVEN_PAGE)   ? table_pointer_high :
        (issue_op == ITS_OP_READ_TABLE_CURRENT_PAGE) ? current_page :
                                                       FINAL_PAGE;

    // ==================================================================
    // Sequencing
    // ==================================================================
    // The discarded slot refuses issue, so nothing can act during it.
    // A taken skip and a table read each cost one extra cycle in which nothing is taken.
    assign issue_ready = (state == ITS_ST_IDLE);
    assign skip_slot   = (state == ITS_ST_SKIP_SLOT);

    always_comb begin
        next_state = state;
        case (state)
            ITS_ST_IDLE: begin
                if (skip_taken) begin
                    next_state = ITS_ST_SKIP_SLOT;
                end else if (accept && op_table) begin
                    next_state = ITS_ST_TABLE_FETCH;
                end
            end
            ITS_ST_TABLE_FETCH: next_state = ITS_ST_IDLE;
            ITS_ST_SKIP_SLOT:   next_state = ITS_ST_IDLE;
            default:            next_state = ITS_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ITS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // Table fetch: address is issued when accepted, word returns next cycle.
    // ==================================================================
    // The program word must stand on its bus while the strobe is high; it is taken
    // at the edge that leaves the fetch state.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_addr    <= '0;
            prog_read_en <= 1'b0;
        end else begin
            prog_read_en <= accept && op_table;
            if (accept && op_table) begin
                prog_addr <= {table_page, table_pointer_low};
            end
        end
    end

    // ==================================================================
    // Result write-back
    // ==================================================================
    // The fetch state comes first: nothing can be accepted while it lasts, so the
    // two branches never compete for the same registers.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            working_register <= WORKING_RESET;
            table_high_latch <= TABLE_HIGH_RESET;
            zero_flag        <= ZERO_FLAG_RESET;
            mem_write_en     <= 1'b0;
            mem_write_data   <= ZERO_BYTE;
        end else begin
            mem_write_en <= 1'b0;
            if (state == ITS_ST_TABLE_FETCH) begin
                mem_write_en     <= 1'b1;
                mem_write_data   <= prog_read_data[DATA_WIDTH-1:0];
                table_high_latch <= prog_read_data[PROG_WIDTH-1:DATA_WIDTH];
            end else if (accept) begin
                case (issue_op)
                    ITS_OP_NIBBLE_EXCHANGE: begin
                        mem_write_en   <= 1'b1;
                        mem_write_data <= swapped;
                    end
                    ITS_OP_NIBBLE_EXCHANGE_TO_WORKING: working_register <= swapped;
                    ITS_OP_COPY_THEN_SKIP_ON_ZERO: working_register <= mem_read_data;
                    ITS_OP_EXCLUSIVE_OR_TO_WORKING: begin
                        working_register <= xor_mem;
                        zero_flag        <= (xor_mem == ZERO_BYTE);
                    end
                    ITS_OP_EXCLUSIVE_OR_INTO_MEMORY: begin
                        mem_write_en   <= 1'b1;
                        mem_write_data <= xor_mem;
                        zero_flag      <= (xor_mem == ZERO_BYTE);
                    end
                    ITS_OP_EXCLUSIVE_OR_IMMEDIATE: begin
                        working_register <= xor_imm;
                        zero_flag        <= (xor_imm == ZERO_BYTE);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    // Every check below is silent while reset is held.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_swap_memory: assert property (
        accept && issue_op == ITS_OP_NIBBLE_EXCHANGE |=> mem_write_en
            && mem_write_data == {$past(mem_read_data[3:0]), $past(mem_read_data[7:4])})
        else $error("nibble exchange wrote wrong byte");
    chk_swap_working: assert property (
        accept && issue_op == ITS_OP_NIBBLE_EXCHANGE_TO_WORKING |=> !mem_write_en
            && working_register == {$past(mem_read_data[3:0]), $past(mem_read_data[7:4])}
            && $stable(zero_flag))
        else $error("exchange to working register wrong");
    chk_skip_byte: assert property (
        accept && issue_op == ITS_OP_SKIP_IF_ZERO && mem_read_data == 8'h00
            |=> skip_slot ##1 !skip_slot)
        else $error("zero byte did not skip");
    chk_skip_cost: assert property (
        accept && issue_op == ITS_OP_SKIP_IF_ZERO && mem_read_data != 8'h00
            |=> !skip_slot && issue_ready)
        else $error("nonzero byte skipped");
    chk_copy_skip: assert property (
        accept && issue_op == ITS_OP_COPY_THEN_SKIP_ON_ZERO
            |=> working_register == $past(mem_read_data) && skip_slot == (working_register == 8'h00))
        else $error("copy and test wrong");
    chk_bit_skip: assert property (
        accept && issue_op == ITS_OP_SKIP_IF_BIT_ZERO |=> skip_slot == $past(bit_zero))
        else $error("bit test skip wrong");
    chk_final_page: assert property (
        accept && issue_op == ITS_OP_READ_TABLE_FINAL_PAGE
            |=> prog_read_en && prog_addr == {8'hFF, $past(table_pointer_low)}
            ##1 mem_write_en && table_high_latch == $past(prog_read_data[15:8]))
        else $error("final page table read wrong");
    chk_given_page: assert property (
        accept && issue_op == ITS_OP_READ_TABLE_GIVEN_PAGE
            |=> prog_addr == {$past(table_pointer_high), $past(table_pointer_low)})
        else $error("given page address wrong");
    chk_xor_memory: assert property (
        accept && issue_op == ITS_OP_EXCLUSIVE_OR_INTO_MEMORY
            |=> mem_write_data == ($past(working_register) ^ $past(mem_read_data))
            && zero_flag == (mem_write_data == 8'h00) && $stable(working_register))
        else $error("xor into memory wrong");
    chk_xor_immediate: assert property (
        accept && issue_op == ITS_OP_EXCLUSIVE_OR_IMMEDIATE
            |=> working_register == ($past(working_register) ^ $past(literal)))
        else $error("xor immediate wrong");
    chk_slot_quiet: assert property (
        skip_slot |=> !mem_write_en && $stable(working_register) && $stable(zero_flag)
            && $stable(table_high_latch))
        else $error("discarded slot had effects");

    // ==================================================================
    // Checks: flags and side effects
    // ==================================================================
    // Operations that must leave the flags alone are watched one by one, so a decode
    // slip that lets the zero flag follow the wrong operation is caught.
    chk_swap_quiet: assert property (
        accept && issue_op == ITS_OP_NIBBLE_EXCHANGE
            |=> $stable(zero_flag) && $stable(working_register) && $stable(table_high_latch))
        else $error("nibble exchange touched a register");
    chk_skip_quiet: assert property (
        accept && issue_op == ITS_OP_SKIP_IF_ZERO
            |=> !mem_write_en && $stable(working_register) && $stable(zero_flag)
            && $stable(table_high_latch))
        else $error("byte zero test had side effects");
    chk_copy_quiet: assert property (
        accept && issue_op == ITS_OP_COPY_THEN_SKIP_ON_ZERO
            |=> !mem_write_en && $stable(zero_flag) && $stable(table_high_latch))
        else $error("copy and test had side effects");
    chk_copy_nonzero: assert property (
        accept && issue_op == ITS_OP_COPY_THEN_SKIP_ON_ZERO && mem_read_data != 8'h00
            |=> !skip_slot && issue_ready)
        else $error("copy and test skipped on nonzero byte");
    chk_bit_quiet: assert property (
        accept && issue_op == ITS_OP_SKIP_IF_BIT_ZERO
            |=> !mem_write_en && $stable(working_register) && $stable(zero_flag))
        else $error("bit zero test had side effects");
    chk_slot_refuse: assert property (
        skip_slot |-> !issue_ready && !prog_read_en)
        else $error("discarded slot accepted an instruction");
    chk_slot_length: assert property (
        skip_taken |=> !issue_ready ##1 issue_ready)
        else $error("taken skip did not last two cycles");
    chk_xor_working: assert property (
        accept && issue_op == ITS_OP_EXCLUSIVE_OR_TO_WORKING
            |=> working_register == ($past(working_register) ^ $past(mem_read_data))
            && zero_flag == (working_register == 8'h00) && !mem_write_en)
        else $error("xor to working register wrong");
    chk_zero_source: assert property (
        !(accept && (issue_op == ITS_OP_EXCLUSIVE_OR_TO_WORKING
            || issue_op == ITS_OP_EXCLUSIVE_OR_INTO_MEMORY
            || issue_op == ITS_OP_EXCLUSIVE_OR_IMMEDIATE)) |=> $stable(zero_flag))
        else $error("zero flag moved without an xor");
    chk_xor_write: assert property (
        accept && issue_op == ITS_OP_EXCLUSIVE_OR_INTO_MEMORY |=> mem_write_en)
        else $error("xor into memory did not write");
    chk_imm_flag: assert property (
        accept && issue_op == ITS_OP_EXCLUSIVE_OR_IMMEDIATE
            |=> !mem_write_en && zero_flag == (working_register == 8'h00))
        else $error("xor immediate flag or write wrong");

    // ==================================================================
    // Checks: table reads
    // ==================================================================
    // Both halves of the fetched word must land at the same edge.
    chk_current_page: assert property (
        accept && issue_op == ITS_OP_READ_TABLE_CURRENT_PAGE
            |=> prog_read_en && prog_addr == {$past(current_page), $past(table_pointer_low)}
            ##1 mem_write_en && mem_write_data == $past(prog_read_data[7:0])
            && table_high_latch == $past(prog_read_data[15:8]))
        else $error("current page table read wrong");
    chk_given_data: assert property (
        accept && issue_op == ITS_OP_READ_TABLE_GIVEN_PAGE
            |=> prog_read_en ##1 mem_write_en && mem_write_data == $past(prog_read_data[7:0])
            && table_high_latch == $past(prog_read_data[15:8]))
        else $error("given page table data wrong");
    chk_final_data: assert property (
        accept && issue_op == ITS_OP_READ_TABLE_FINAL_PAGE
            |=> ##1 mem_write_data == $past(prog_read_data[7:0]))
        else $error("final page low byte wrong");
    chk_table_quiet: assert property (
        accept && op_table
            |=> !issue_ready && $stable(working_register) && $stable(zero_flag)
            ##1 $stable(working_register) && $stable(zero_flag))
        else $error("table read disturbed a register");
    chk_read_pulse: assert property (
        prog_read_en |=> !prog_read_en)
        else $error("program read strobe held too long");
    chk_latch_source: assert property (
        state != ITS_ST_TABLE_FETCH |=> $stable(table_high_latch))
        else $error("table latch moved outside a fetch");


    cov_skip_taken: cover property (skip_taken);
    cov_table_read: cover property (accept && op_table ##2 mem_write_en);
    cov_xor_zero:   cover property (accept && issue_op == ITS_OP_EXCLUSIVE_OR_TO_WORKING
                                    ##1 zero_flag);
    cov_slot_refused: cover property (skip_slot && issue_valid);
    cov_bit_skip:     cover property (accept && issue_op == ITS_OP_SKIP_IF_BIT_ZERO && bit_zero);
endmodule : its_exec
`default_nettype wire

// ==== sim/tb_its_exec.sv ====
// Self-checking bench for the instruction tail execution unit.
`default_nettype none
module tb_its_exec
    import its_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Signals and model state
    logic        ref_clk, reset_n, issue_valid, issue_ready, mem_write_en;
    logic        prog_read_en, zero_flag, skip_slot, m_zf;
    its_op_type  issue_op, op;
    logic [2:0]  bit_select;
    logic [7:0]  literal, mem_read_data, table_pointer_low, table_pointer_high;
    logic [7:0]  current_page, mem_write_data, working_register, table_high_latch;
    logic [7:0]  m_wr, m_tl, m;
    logic [15:0] prog_read_data, prog_addr, rng;
    int          failures, checks_done, i;
    its_exec i_its_exec (.ref_clk(ref_clk), .reset_n(reset_n), .issue_valid(issue_valid),
        .issue_op(issue_op), .bit_select(bit_select), .literal(literal),
        .mem_read_data(mem_read_data), .table_pointer_low(table_pointer_low),
        .table_pointer_high(table_pointer_high), .current_page(current_page),
        .prog_read_data(prog_read_data), .issue_ready(issue_ready),
        .mem_write_en(mem_write_en), .mem_write_data(mem_write_data),
        .prog_addr(prog_addr), .prog_read_en(prog_read_en),
        .working_register(working_register), .table_high_latch(table_high_latch),
        .zero_flag(zero_flag), .skip_slot(skip_slot));
    // ==================================================
    // Helpers
    function automatic logic [7:0] rnd8();
        rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
        return rng[7:0];
    endfunction : rnd8
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Called at a falling edge; leaves the bench at a falling edge ready for the next issue.
    task automatic run_op(input its_op_type op, input logic [7:0] m);
        logic [7:0]  swp, res;
        logic [15:0] pw, addr;
        logic        we, skp, tbl;
        int          n;
        for (n = 0; n < 4 && issue_ready !== 1'b1; n++) @(negedge ref_clk);
        if (n == 4) begin
            failures++;
            close_out();
        end
        issue_valid = 1'b1;
        issue_op = op;
        mem_read_data = m;
        bit_select = 3'(rnd8());
        literal = rnd8();
        table_pointer_low = rnd8();
        table_pointer_high = rnd8();
        current_page = rnd8();
        swp = {m[3:0], m[7:4]};
        we = 1'b0;
        skp = 1'b0;
        res = m_wr ^ m;
        tbl = op inside {ITS_OP_READ_TABLE_GIVEN_PAGE, ITS_OP_READ_TABLE_CURRENT_PAGE,
                         ITS_OP_READ_TABLE_FINAL_PAGE};
        addr = {(op == ITS_OP_READ_TABLE_GIVEN_PAGE) ? table_pointer_high :
                (op == ITS_OP_READ_TABLE_CURRENT_PAGE) ? current_page : FINAL_PAGE,
                table_pointer_low};
        case (op)
            ITS_OP_NIBBLE_EXCHANGE: begin
                we = 1'b1;
                res = swp;
            end
            ITS_OP_NIBBLE_EXCHANGE_TO_WORKING: m_wr = swp;
            ITS_OP_SKIP_IF_ZERO: skp = (m == ZERO_BYTE);
            ITS_OP_COPY_THEN_SKIP_ON_ZERO: begin
                m_wr = m;
                skp = (m == ZERO_BYTE);
            end
            ITS_OP_SKIP_IF_BIT_ZERO: skp = !m[bit_select];
            ITS_OP_EXCLUSIVE_OR_TO_WORKING: begin
                m_wr = res;
                m_zf = (res == ZERO_BYTE);
            end
            ITS_OP_EXCLUSIVE_OR_INTO_MEMORY: begin
                we = 1'b1;
                m_zf = (res == ZERO_BYTE);
            end
            ITS_OP_EXCLUSIVE_OR_IMMEDIATE: begin
                m_wr = m_wr ^ literal;
                m_zf = (m_wr == ZERO_BYTE);
            end
            default: ;
        endcase
        @(negedge ref_clk);
        chk("prog_read_en", 16'(tbl), 16'(prog_read_en));
        if (tbl) begin
            chk("prog_addr", addr, prog_addr);
            chk("table mem_write_en", 16'h0000, 16'(mem_write_en));
            issue_valid = 1'b0;
            pw = {rnd8(), rnd8()};
            prog_read_data = pw;
            m_tl = pw[15:8];
            res = pw[7:0];
            we = 1'b1;
            @(negedge ref_clk);
        end else begin
            chk("skip_slot", 16'(skp), 16'(skip_slot));
            chk("issue_ready", 16'(!skp), 16'(issue_ready));
            if (skp) begin
                issue_op = ITS_OP_EXCLUSIVE_OR_IMMEDIATE;
                @(negedge ref_clk);
                chk("slot end", 16'h0003, {14'h0000, issue_ready, !skip_slot});
            end
        end
        chk("mem_write_en", 16'(we), 16'(mem_write_en));
        if (we) chk("mem_write_data", 16'(res), 16'(mem_write_data));
        chk("working_register", 16'(m_wr), 16'(working_register));
        chk("table_high_latch", 16'(m_tl), 16'(table_high_latch));
        chk("zero_flag", 16'(m_zf), 16'(zero_flag));
    endtask : run_op
    // ==================================================
    // Clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        close_out();
    end
    initial begin
        failures = 0;
        checks_done = 0;
        rng = 16'd29362;
        {reset_n, issue_valid, bit_select, literal, mem_read_data} = '0;
        {table_pointer_low, table_pointer_high, current_page, prog_read_data} = '0;
        issue_op = ITS_OP_NONE;
        {m_wr, m_tl, m_zf} = {WORKING_RESET, TABLE_HIGH_RESET, ZERO_FLAG_RESET};
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        for (i = 0; i < 84; i++) begin
            if (i == 60) begin
                $display("Test op sweep done");
                issue_valid = 1'b0;
                reset_n = 1'b0;
                @(negedge ref_clk);
                chk("reset state", 16'h8000, {issue_ready, skip_slot, mem_write_en,
                    zero_flag, working_register, table_high_latch[3:0]});
                {m_wr, m_tl, m_zf} = {WORKING_RESET, TABLE_HIGH_RESET, ZERO_FLAG_RESET};
                reset_n = 1'b1;
                @(negedge ref_clk);
            end
            op = its_op_type'(1 + i % 11);
            m = (i % 4 == 1) ? ZERO_BYTE : (i % 4 == 3) ? m_wr : rnd8();
            run_op(op, m);
        end
        issue_valid = 1'b0;
        $display("Test reset and rerun done");
        close_out();
    end
endmodule : tb_its_exec
`default_nettype wire
